// >>> sep_pkg.sv
// Purpose: shared constants and types for the serial eeprom page-write slave
// Assumes: serial pins sampled by the 25 MHz core clock
// Notes: commands keep two address or don't-care bits in positions 4:3
package sep_pkg;
	localparam int ADDR_W    = 10;
	localparam int PAGE_BITS = 4;
	localparam int PAGE_LEN  = 16;
	localparam int BYTE_W    = 8;
	localparam int MEM_DEPTH = 1024;
	localparam logic [7:0] CMD_MASK      = 8'hE7;
	localparam logic [7:0] CMD_SET_LATCH = 8'h06;
	localparam logic [7:0] CMD_CLR_LATCH = 8'h04;
	localparam logic [7:0] CMD_STAT_RD   = 8'h05;
	localparam logic [7:0] CMD_STAT_WR   = 8'h01;
	localparam logic [7:0] CMD_ARR_RD    = 8'h03;
	localparam logic [7:0] CMD_ARR_WR    = 8'h02;
	localparam logic [7:0] ERASED_BYTE   = 8'hFF;
	localparam logic [1:0] PROTECT_INIT  = 2'h0;
	localparam logic [3:0] STATUS_TOP    = 4'hF;
	localparam logic [2:0] BIT_LAST      = 3'h7;
	localparam int PROG_TIME_US = 10;
	localparam int CLK_MHZ      = 25;
	localparam int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;
	localparam int LATCH_EARLY  = 4;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
	} sep_word_type;

	typedef struct packed {
		logic       sck;
		logic       sel_n;
		logic       mosi;
		logic       pause_n;
		logic       wp_n;
	} sep_pins_type;
endpackage

// >>> sep_fifo.sv
// Purpose: small word buffer between page loader and programming engine
// Assumes: single clock
// Notes: honest full and empty
module sep_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             flush
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW:0]      cnt_reg;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem_reg[rd_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push)
			mem_reg[wr_reg] <= in_data;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else if (flush) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push)
				wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
			if (pop)
				rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// >>> sep_slave.sv
// Purpose: serial eeprom slave with 16-byte page programming
// Assumes: serial pins asynchronous to clk, reset acts as power-up
// Notes: page bytes are staged in a page buffer via the fifo
// Notes on behaviour
// - one programming cycle stores at most 16 bytes
// - in-page counter wraps from 1111 to 0000
// - program only if select rises on byte boundary
// - power-up leaves device idle, deselected, unpaused
// - power-up clears the write latch
// - protection bits survive reset
// - invalid select or pause edges are ignored
// - array access while busy deselects device
// - after latch commands or status read, wait
// - write protect low clears the latch
// - array starts erased to all ones
// - protection bits start cleared
// - sample on rising edge, drive on falling
// - write and latch-set command encodings
// - busy flag high during cycle, latch clears early, 3 cycles before busy falls
module sep_slave
	import sep_pkg::*;
#(
	parameter int PROG_COUNT = PROG_CYCLES
) (
	// clock and power-up reset
	input  wire logic                 clk,
	input  wire logic                 reset,
	// serial pins
	input  wire sep_pkg::sep_pins_type pins,
	output logic                      miso_o,
	output logic                      miso_oe,
	// status
	output logic                      write_busy_flag,
	output logic                      write_latch_flag,
	output logic                      block_protect_hi,
	output logic                      block_protect_lo
);
	import sep_pkg::*;

	typedef enum {ST_IDLE, ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA,
		ST_SDATA, ST_STWR, ST_WAIT} sep_state_type;

	// two-flop synchronisers
	logic [4:0] s1_reg, s2_reg;
	logic       sck_d_reg;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s1_reg    <= 5'h0F; // idle pins, sck low
			s2_reg    <= 5'h0F;
			sck_d_reg <= 1'b0;
		end else begin
			s1_reg    <= pins;
			s2_reg    <= s1_reg;
			sck_d_reg <= s2_reg[4];
		end
	end
	logic sck, sel_n, mosi, pause_n, wp_n;
	logic sck_rise, sck_fall;
	assign sck      = s2_reg[4];
	assign sel_n    = s2_reg[3];
	assign mosi     = s2_reg[2];
	assign pause_n  = s2_reg[1];
	assign wp_n     = s2_reg[0];
	assign sck_rise = sck && !sck_d_reg;
	assign sck_fall = !sck && sck_d_reg;

	// select and pause edge tracking
	logic sel_d_reg;
	logic pause_d_reg;
	logic paused_reg;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sel_d_reg   <= 1'b1;
			pause_d_reg <= 1'b1;
			paused_reg  <= 1'b0;
		end else begin
			sel_d_reg   <= sel_n;
			pause_d_reg <= pause_n;
			// pause edges count only when selected and clock low
			if (!sel_n && !sck && pause_n != pause_d_reg)
				paused_reg <= !pause_n;
		end
	end
	logic sel_rise, sel_fall, active;
	assign sel_rise = sel_n && !sel_d_reg;
	assign sel_fall = !sel_n && sel_d_reg;
	assign active   = !sel_n && !paused_reg;

	function automatic logic cmd_is(input logic [7:0] c,
		input logic [7:0] code);
		return (c & CMD_MASK) == code;
	endfunction

	sep_state_type state_reg;
	logic [7:0]        shift_reg;
	logic [2:0]        bit_reg;
	logic              byte_done_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [4:0]        nbytes_reg;
	logic [7:0]        out_reg;
	logic              stat_pend_reg;
	logic [1:0]        stat_new_reg;
	logic              launch;
	logic              stat_launch;
	logic              fifo_in_valid;
	logic              fifo_in_ready;
	logic              fifo_out_valid;
	logic [7:0]        mem [MEM_DEPTH] = '{default: ERASED_BYTE};
	logic [7:0]        status_byte;
	logic [7:0]        next_byte;
	sep_word_type      fifo_out;

	assign next_byte = {shift_reg[6:0], mosi};
	assign status_byte = {STATUS_TOP, block_protect_hi, block_protect_lo,
		write_latch_flag, write_busy_flag};
	// rise on byte boundary with clock low starts the cycle
	assign launch = sel_rise && !sck && byte_done_reg
		&& state_reg == ST_WDATA && nbytes_reg != '0;
	assign stat_launch = sel_rise && !sck && stat_pend_reg;
	assign fifo_in_valid = active && sck_rise && state_reg == ST_WDATA
		&& bit_reg == BIT_LAST;

	// protocol engine, samples on rising, drives on falling
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg     <= ST_IDLE;
			shift_reg     <= '0;
			bit_reg       <= '0;
			byte_done_reg <= 1'b0;
			addr_reg      <= '0;
			nbytes_reg    <= '0;
			out_reg       <= '0;
			stat_pend_reg <= 1'b0;
			stat_new_reg  <= '0;
		end else if (sel_n || sel_fall) begin
			state_reg     <= sel_n ? ST_IDLE : ST_CMD;
			bit_reg       <= '0;
			byte_done_reg <= 1'b0;
			nbytes_reg    <= sel_n ? nbytes_reg : '0;
			stat_pend_reg <= sel_n ? 1'b0 : stat_pend_reg;
		end else if (active && sck_rise) begin
			shift_reg     <= next_byte;
			bit_reg       <= bit_reg + 3'h1;
			byte_done_reg <= (bit_reg == BIT_LAST);
			stat_pend_reg <= 1'b0;
			if (bit_reg == BIT_LAST) begin
				unique case (state_reg)
					ST_CMD: begin
						addr_reg[ADDR_W-1:8] <= next_byte[4:3];
						if (cmd_is(next_byte, CMD_SET_LATCH)
							|| cmd_is(next_byte, CMD_CLR_LATCH))
							state_reg <= ST_WAIT;
						else if (cmd_is(next_byte, CMD_STAT_RD)) begin
							state_reg <= ST_SDATA;
							out_reg   <= status_byte;
						end else if (cmd_is(next_byte, CMD_STAT_WR))
							state_reg <= (write_latch_flag && !write_busy_flag)
								? ST_STWR : ST_WAIT;
						else if (cmd_is(next_byte, CMD_ARR_WR)
							|| cmd_is(next_byte, CMD_ARR_RD))
							// busy array access deselects
							state_reg <= write_busy_flag ? ST_IDLE
								: (cmd_is(next_byte, CMD_ARR_WR)
								&& !write_latch_flag) ? ST_WAIT : ST_ADDR;
						else
							state_reg <= ST_IDLE;
						nbytes_reg <= cmd_is(next_byte, CMD_ARR_WR)
							? 5'(PAGE_LEN) : '0;
					end
					ST_ADDR: begin
						addr_reg[7:0] <= next_byte;
						if (nbytes_reg == '0) begin
							state_reg <= ST_RDATA;
							out_reg   <= mem[{addr_reg[ADDR_W-1:8], next_byte}];
						end else begin
							state_reg  <= ST_WDATA;
							nbytes_reg <= '0;
						end
					end
					ST_WDATA: begin
						// wrap within the page, upper bits fixed
						addr_reg[PAGE_BITS-1:0] <= addr_reg[PAGE_BITS-1:0]
							+ 4'h1;
						if (nbytes_reg != 5'(PAGE_LEN))
							nbytes_reg <= nbytes_reg + 5'h1;
					end
					ST_RDATA: begin
						addr_reg <= addr_reg + 10'h001;
						out_reg  <= mem[addr_reg + 10'h001];
					end
					ST_SDATA: state_reg <= ST_WAIT;
					ST_STWR: begin
						stat_new_reg  <= next_byte[3:2];
						stat_pend_reg <= 1'b1;
						state_reg     <= ST_WAIT;
					end
					ST_WAIT: state_reg <= ST_WAIT;
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// serial output, shifted on falling edges
	logic [7:0] tx_reg;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tx_reg  <= '0;
			miso_oe <= 1'b0;
		end else begin
			miso_oe <= active && (state_reg == ST_RDATA
				|| state_reg == ST_SDATA);
			if (active && sck_fall)
				tx_reg <= (bit_reg == '0) ? out_reg : {tx_reg[6:0], 1'b0};
		end
	end
	assign miso_o = tx_reg[7];

	// page buffer staging via fifo
	sep_word_type fifo_in;
	assign fifo_in.addr = addr_reg;
	assign fifo_in.data = next_byte;
	sep_fifo #(.WIDTH($bits(sep_word_type)), .DEPTH(4)) u_fifo (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (fifo_out_valid),
		.out_ready (1'b1),
		.out_data  (fifo_out),
		.flush     (sel_fall)
	);

	logic [7:0] page_reg [PAGE_LEN];
	logic [ADDR_W-1:PAGE_BITS] page_base_reg;
	always_ff @(posedge clk) begin
		if (fifo_out_valid)
			page_reg[fifo_out.addr[PAGE_BITS-1:0]] <= fifo_out.data;
	end

	logic [PAGE_LEN-1:0] dirty_reg;
	logic [31:0]         timer_reg;
	logic                mem_commit;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dirty_reg       <= '0;
			page_base_reg   <= '0;
			write_busy_flag <= 1'b0;
			timer_reg       <= '0;
		end else begin
			if (sel_fall && !write_busy_flag)
				dirty_reg <= '0;
			else if (fifo_out_valid)
				dirty_reg[fifo_out.addr[PAGE_BITS-1:0]] <= 1'b1;
			if (fifo_in_valid)
				page_base_reg <= addr_reg[ADDR_W-1:PAGE_BITS];
			if (launch || stat_launch) begin
				write_busy_flag <= 1'b1;
				timer_reg       <= 32'(PROG_COUNT);
			end else if (write_busy_flag) begin
				timer_reg <= timer_reg - 32'h1;
				if (timer_reg == 32'h1) begin
					write_busy_flag <= 1'b0;
					dirty_reg       <= '0;
				end
			end
		end
	end
	assign mem_commit = write_busy_flag && timer_reg == 32'h1;

	// protection ranges applied at commit
	function automatic logic is_protected(input logic [ADDR_W-1:0] a,
		input logic [1:0] bp);
		unique case (bp)
			2'h0: return 1'b0;
			2'h1: return a[9:8] == 2'h3;
			2'h2: return a[9];
			default: return 1'b1;
		endcase
	endfunction

	// array commit, protected bytes skipped
	always_ff @(posedge clk) begin
		for (int i = 0; i < PAGE_LEN; i++) begin
			if (mem_commit && dirty_reg[i] && !is_protected(
				{page_base_reg, 4'(i)}, {block_protect_hi, block_protect_lo}))
				mem[{page_base_reg, 4'(i)}] <= page_reg[i];
		end
	end

	// nonvolatile protection bits, not reset
	logic [1:0] protect_reg     = PROTECT_INIT;
	logic       stat_commit_reg = 1'b0;
	assign {block_protect_hi, block_protect_lo} = protect_reg;
	always_ff @(posedge clk) begin
		if (stat_launch)
			stat_commit_reg <= 1'b1;
		else if (mem_commit || launch)
			stat_commit_reg <= 1'b0;
		if (mem_commit && stat_commit_reg)
			protect_reg <= stat_new_reg;
	end

	// write enable latch
	logic cmd_done;
	assign cmd_done = active && sck_rise && bit_reg == BIT_LAST
		&& state_reg == ST_CMD;
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			write_latch_flag <= 1'b0;
		else if (!wp_n)
			write_latch_flag <= 1'b0;
		else if (write_busy_flag && timer_reg == 32'(LATCH_EARLY))
			write_latch_flag <= 1'b0;
		else if (cmd_done && cmd_is(next_byte, CMD_SET_LATCH))
			write_latch_flag <= 1'b1;
		else if (cmd_done && cmd_is(next_byte, CMD_CLR_LATCH))
			write_latch_flag <= 1'b0;
	end

	// checks
	busy_start_a: assert property (@(posedge clk) disable iff (reset)
		(launch || stat_launch) |=> write_busy_flag)
		else $error("busy not raised at launch");
	wp_clear_a: assert property (@(posedge clk) disable iff (reset)
		!wp_n |=> !write_latch_flag)
		else $error("latch not cleared by write protect");
	wrap_a: assert property (@(posedge clk) disable iff (reset)
		(fifo_in_valid && addr_reg[3:0] == 4'hF)
		|=> addr_reg[3:0] == 4'h0)
		else $error("page address did not wrap");
	upper_fix_a: assert property (@(posedge clk) disable iff (reset)
		fifo_in_valid |=> addr_reg[9:4] == $past(addr_reg[9:4]))
		else $error("upper address moved");
	busy_access_a: assert property (@(posedge clk) disable iff (reset)
		(cmd_done && write_busy_flag && cmd_is(next_byte, CMD_ARR_RD))
		|=> state_reg == ST_IDLE)
		else $error("array access during busy not cancelled");
	wait_state_a: assert property (@(posedge clk) disable iff (reset)
		(cmd_done && wp_n && cmd_is(next_byte, CMD_SET_LATCH))
		|=> state_reg == ST_WAIT && write_latch_flag)
		else $error("latch command did not wait");
	no_launch_a: assert property (@(posedge clk) disable iff (reset)
		(sel_rise && !byte_done_reg && !stat_pend_reg)
		|=> !write_busy_flag || $past(write_busy_flag))
		else $error("programming started off byte boundary");
	busy_hold_a: assert property (@(posedge clk) disable iff (reset)
		(write_busy_flag && timer_reg > 32'h2) |=> write_busy_flag)
		else $error("busy dropped early");
	pause_ign_a: assert property (@(posedge clk) disable iff (reset)
		(sel_n) |=> paused_reg == $past(paused_reg))
		else $error("pause changed while deselected");
	fifo_room_a: assert property (@(posedge clk) disable iff (reset)
		fifo_in_valid |-> fifo_in_ready)
		else $error("page byte lost at full buffer");
	page_cov: cover property (@(posedge clk) launch);
	stat_cov: cover property (@(posedge clk) stat_launch);
	wrap_cov: cover property (@(posedge clk)
		fifo_in_valid && addr_reg[3:0] == 4'hF);
endmodule

// >>> sep_host.sv
// Purpose: host serial master model driving the eeprom slave pins
// Assumes: serial clock of 320 ns made from 8 core clocks, idle low
// Notes: pins change just after core clock edges; sck stands still between
// Notes: frames and a released data line shows the inverse of its last bit
module sep_host (
	// core clock
	input  wire logic             clk,
	// serial pins toward device
	output sep_pkg::sep_pins_type pins,
	input  wire logic             miso
);
	timeunit 1ns;
	timeprecision 1ns;
	import sep_pkg::*;

	localparam int HALF = 4;

	initial begin
		pins = '{sck: 1'b0, sel_n: 1'b1, mosi: 1'b0, pause_n: 1'b1, wp_n: 1'b1};
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic select();
		@(posedge clk);
		pins.sel_n <= 1'b0;
		wait_clk(HALF);
	endtask

	// sck is low here, so a rise after whole bytes starts a write
	task automatic deselect();
		wait_clk(HALF);
		pins.sel_n <= 1'b1;
		pins.mosi  <= ~pins.mosi;
		wait_clk(HALF);
	endtask

	// msb first; mosi set in sck low, miso taken just before sck rises
	task automatic shift_bits(input int n, input logic [7:0] tx,
		output logic [7:0] rx);
		rx = 8'h00;
		for (int i = n - 1; i >= 0; i--) begin
			pins.mosi <= tx[i];
			wait_clk(HALF);
			rx[i] = miso;
			pins.sck <= 1'b1;
			wait_clk(HALF);
			pins.sck <= 1'b0;
		end
	endtask

	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		shift_bits(8, tx, rx);
	endtask

	task automatic stray_bits(input logic [2:0] b);
		logic [7:0] rx;
		shift_bits(3, {5'h00, b}, rx);
	endtask

	// pause entered and left with sck low; junk clocked meanwhile
	task automatic pause_junk(input logic [7:0] junk);
		logic [7:0] rx;
		wait_clk(HALF);
		pins.pause_n <= 1'b0;
		wait_clk(HALF);
		shift_bits(8, junk, rx);
		wait_clk(HALF);
		pins.pause_n <= 1'b1;
		wait_clk(HALF);
	endtask

	task automatic set_wp(input logic v);
		@(posedge clk);
		pins.wp_n <= v;
	endtask
endmodule

// >>> test_spi_eeprom_page_write_protocol.sv
// Purpose: self-checking bench for the serial eeprom page-write slave
// Assumes: programming count of 300 cycles, above the default 250, host model on the serial pins
// Notes: expected array contents kept in a local byte model
module test_spi_eeprom_page_write_protocol;
	timeunit 1ns;
	timeprecision 1ns;
	import sep_pkg::*;

	localparam int PROG_SIM = 300;
	localparam int LIMIT    = 60000;

	logic               clk;
	logic               reset;
	sep_pins_type       pins;
	logic               miso_o;
	logic               miso_oe;
	logic               busy;
	logic               latch;
	logic               bp_hi;
	logic               bp_lo;
	logic               oe_seen;
	logic [7:0]         mem [0:MEM_DEPTH-1];
	logic [7:0]         rx;
	logic               seen;
	int                 fails;
	int                 checks_done;
	int                 cycles;
	int                 run;
	int                 last_len;

	sep_slave #(.PROG_COUNT(PROG_SIM)) DUT (
		.clk              (clk),
		.reset            (reset),
		.pins             (pins),
		.miso_o           (miso_o),
		.miso_oe          (miso_oe),
		.write_busy_flag  (busy),
		.write_latch_flag (latch),
		.block_protect_hi (bp_hi),
		.block_protect_lo (bp_lo)
	);

	sep_host u_host (
		.clk  (clk),
		.pins (pins),
		.miso (miso_oe ? miso_o : !miso_o) // released line reads inverted
	);

	initial begin
		clk = 1'b0;
		reset = 1'b1;
		oe_seen = 1'b0;
		fails = 0;
		checks_done = 0;
		cycles = 0;
		run = 0;
		last_len = 0;
		for (int i = 0; i < MEM_DEPTH; i++)
			mem[i] = 8'hFF;
	end

	always #20 clk = ~clk;

	// busy run length and data-out activity watchers
	always @(posedge clk) begin
		if (miso_oe === 1'b1)
			oe_seen = 1'b1;
		if (busy === 1'b1)
			run++;
		else if (run != 0) begin
			last_len = run;
			run = 0;
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fails++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen_v,
		input logic [7:0] exp);
		checks_done++;
		if (seen_v !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen_v);
		end
	endtask

	task automatic test_done(input string name);
		$display("test %s done", name);
	endtask

	task automatic do_reset();
		@(posedge clk);
		reset <= 1'b1;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic cmd(input logic [7:0] c);
		u_host.select();
		u_host.xfer(c, rx);
		u_host.deselect();
	endtask

	task automatic wait_rise(output logic s);
		s = 1'b0;
		for (int i = 0; i < 24 && s !== 1'b1; i++) begin
			@(posedge clk);
			if (busy === 1'b1)
				s = 1'b1;
		end
	endtask

	task automatic wait_done();
		last_len = 0;
		for (int i = 0; i < PROG_SIM + 50 && busy !== 1'b0; i++)
			@(posedge clk);
		@(posedge clk);
		check("busy length ok", 8'(last_len >= PROG_SIM &&
			last_len <= PROG_SIM + 2), 8'h01);
		check("latch after write", {7'h00, latch}, 8'h00);
	endtask

	task automatic page_write(input logic [9:0] a, input int n,
		input logic [7:0] base, input logic keep, input logic pause,
		input logic stray);
		u_host.select();
		u_host.xfer(CMD_ARR_WR | {3'h0, a[9:8], 3'h0}, rx);
		u_host.xfer(a[7:0], rx);
		if (pause)
			u_host.pause_junk(8'h5A);
		for (int i = 0; i < n; i++) begin
			u_host.xfer(base + 8'(i), rx);
			if (keep)
				mem[{a[9:4], a[3:0] + 4'(i)}] = base + 8'(i);
		end
		if (stray)
			u_host.stray_bits(3'h5);
		u_host.deselect();
	endtask

	task automatic read_check(input logic [9:0] a, input int n);
		u_host.select();
		u_host.xfer(CMD_ARR_RD | {3'h0, a[9:8], 3'h0}, rx);
		u_host.xfer(a[7:0], rx);
		for (int i = 0; i < n; i++) begin
			u_host.xfer(8'h00, rx);
			check($sformatf("array %h", a + 10'(i)), rx, mem[a + 10'(i)]);
		end
		u_host.deselect();
	endtask

	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);

		check("busy at power-up", {7'h00, busy}, 8'h00);
		check("latch at power-up", {7'h00, latch}, 8'h00);
		check("data out enable idle", {7'h00, miso_oe}, 8'h00);
		check("protect bits shipped", {6'h00, bp_hi, bp_lo}, 8'h00);
		read_check(10'h000, 2);
		test_done("power_up");

		page_write(10'h010, 1, 8'h11, 1'b0, 1'b0, 1'b0);
		wait_rise(seen);
		check("write without latch", {7'h00, seen}, 8'h00);
		read_check(10'h010, 1);
		test_done("no_latch");

		cmd(CMD_SET_LATCH);
		check("latch set", {7'h00, latch}, 8'h01);
		cmd(CMD_CLR_LATCH);
		check("latch clear", {7'h00, latch}, 8'h00);
		u_host.select();
		u_host.xfer(CMD_SET_LATCH, rx);
		u_host.xfer(CMD_CLR_LATCH, rx);
		u_host.deselect();
		check("wait after latch set", {7'h00, latch}, 8'h01);
		u_host.set_wp(1'b0);
		repeat (6) @(posedge clk);
		check("latch after protect pin", {7'h00, latch}, 8'h00);
		u_host.set_wp(1'b1);
		test_done("latch_cmds");

		cmd(CMD_SET_LATCH);
		page_write(10'h1FE, 18, 8'hA0, 1'b1, 1'b1, 1'b0);
		wait_rise(seen);
		check("page write starts", {7'h00, seen}, 8'h01);
		u_host.select();
		u_host.xfer(CMD_STAT_RD, rx);
		u_host.xfer(8'h00, rx);
		u_host.deselect();
		check("status during write", rx, {STATUS_TOP, 4'h3});
		wait_done();
		read_check(10'h1F0, 16);
		test_done("page_wrap");

		cmd(CMD_SET_LATCH);
		page_write(10'h205, 1, 8'h3C, 1'b1, 1'b0, 1'b0);
		wait_rise(seen);
		oe_seen = 1'b0;
		u_host.select();
		u_host.xfer(CMD_ARR_RD, rx);
		u_host.xfer(8'h05, rx);
		u_host.xfer(8'h00, rx);
		u_host.deselect();
		check("read while busy drives", {7'h00, oe_seen}, 8'h00);
		check("busy kept", {7'h00, busy}, 8'h01);
		wait_done();
		read_check(10'h205, 1);
		test_done("busy_read");

		cmd(CMD_SET_LATCH);
		page_write(10'h030, 1, 8'h77, 1'b0, 1'b0, 1'b1);
		wait_rise(seen);
		check("off-boundary select", {7'h00, seen}, 8'h00);
		read_check(10'h030, 1);
		test_done("off_boundary");

		cmd(CMD_SET_LATCH);
		u_host.select();
		u_host.xfer(CMD_STAT_WR, rx);
		u_host.xfer(8'h0C, rx);
		u_host.deselect();
		wait_rise(seen);
		wait_done();
		check("protect bits written", {6'h00, bp_hi, bp_lo}, 8'h03);
		do_reset();
		check("protect bits kept", {6'h00, bp_hi, bp_lo}, 8'h03);
		check("latch after reset", {7'h00, latch}, 8'h00);
		test_done("protect_keep");

		wrap_up();
	end
endmodule
